// ==== port_pins_pkg.sv ====
// Shared constants and carrier types for the two eight-bit port pin blocks.
// Assumes a single 50 MHz core clock and synchronous, active-high reset.
`default_nettype none
package port_pins_pkg;
	localparam int PORT_WIDTH = 8;
	localparam logic [7:0] BUS_PORT_RESET_LATCH = 8'hFF;
	localparam logic [7:0] IO_PORT_RESET_LATCH = 8'hFF;
	localparam int CLK_PERIOD_NS = 20;
	localparam int STRONG_PULLUP_NS = 40;
	localparam int STRONG_PULLUP_CYCLES = (STRONG_PULLUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_IO_BIT = 0;
	localparam int TIMER_TRIG_BIT = 1;
	localparam int SERIAL_RX_BIT = 2;
	localparam int SERIAL_TX_BIT = 3;
	localparam int IRQ_TWO_BIT = 4;
	localparam int IRQ_THREE_BIT = 5;
	localparam int IRQ_FOUR_BIT = 6;
	localparam int IRQ_FIVE_BIT = 7;

	// Drive of one pin group: o = level driven, oe = strong drive on, wpu = weak pullup on
	typedef struct packed {
		logic [7:0] o;
		logic [7:0] oe;
		logic [7:0] wpu;
	} pin_drive_t;

	typedef struct packed {
		logic edge_irq_five;
		logic edge_irq_four;
		logic edge_irq_three;
		logic edge_irq_two;
	} irq_set_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ADDR = 2'b01,
		BUS_DATA = 2'b11
	} bus_phase_t;
endpackage : port_pins_pkg
`default_nettype wire

// ==== edge_irq_flag.sv ====
// One edge-detected interrupt input with its pending flag.
// Assumes the pin level may be asynchronous to ref_clk_i; two stages synchronise it.
`default_nettype none
module edge_irq_flag #(
	parameter bit RISING = 1'b1
) (
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic pin_i,
	input wire logic clear_i,
	output logic pending_o
);
	logic sync_a;
	logic sync_b;
	logic last;
	logic hit;

	// Two stages; only sync_b is looked at
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			sync_a <= 1'b1;
			sync_b <= 1'b1;
			last <= 1'b1;
		end else begin
			sync_a <= pin_i;
			sync_b <= sync_a;
			last <= sync_b;
		end
	end

	assign hit = RISING ? (sync_b & ~last) : (~sync_b & last);

	// Set wins over a clear in the same cycle so no edge is lost
	always_ff @(posedge ref_clk_i) begin
		if (srst_i)
			pending_o <= 1'b0;
		else if (hit)
			pending_o <= 1'b1;
		else if (clear_i)
			pending_o <= 1'b0;
	end
endmodule : edge_irq_flag
`default_nettype wire

// ==== port_pins.sv ====
// Pin logic of the bus port (open drain, multiplexed address/data) and the quasi-bidirectional I/O port.
// Assumes the core drives latch writes and bus cycles; the bench resolves pin levels from the enables.
`default_nettype none
module port_pins #(
	parameter int WIDTH = port_pins_pkg::PORT_WIDTH,
	parameter int PULSE_CYCLES = port_pins_pkg::STRONG_PULLUP_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic srst_i,
	// Bus port, software side and external memory side
	input wire logic bus_latch_we_i,
	input wire logic [7:0] bus_latch_wdata_i,
	input wire logic ext_bus_en_i,
	input wire logic addr_strobe_i,
	input wire logic [7:0] low_addr_i,
	input wire logic data_drive_i,
	input wire logic [7:0] data_out_i,
	output logic [7:0] muxed_addr_data_bus_o,
	output logic [7:0] muxed_addr_data_bus_oe_o,
	output logic [7:0] muxed_addr_data_bus_wpu_o,
	input wire logic [7:0] muxed_addr_data_bus_i,
	output logic [7:0] bus_pin_level_o,
	// I/O port
	input wire logic io_latch_we_i,
	input wire logic [7:0] io_latch_wdata_i,
	input wire logic [7:0] alt_enable_i,
	input wire logic [7:0] alt_out_i,
	output logic [7:0] io_pin_o,
	output logic [7:0] io_pin_oe_o,
	output logic [7:0] io_pin_wpu_o,
	input wire logic [7:0] io_pin_i,
	output logic [7:0] io_latch_o,
	output logic [7:0] io_pin_level_o,
	// Alternate function taps
	output logic timer_two_io_o,
	output logic timer_two_reload_trigger_o,
	output logic second_serial_receive_o,
	input wire logic irq_clear_i,
	output port_pins_pkg::irq_set_t irq_pending_o
);
	logic [7:0] bus_latch;
	logic [7:0] io_latch;
	logic [7:0] pulse_active;
	logic [7:0] pulse_last;
	logic [7:0] pulse_cnt [WIDTH];
	logic [7:0] eff_io;
	port_pins_pkg::bus_phase_t phase;
	port_pins_pkg::pin_drive_t bus_drv;
	port_pins_pkg::pin_drive_t io_drv;
	port_pins_pkg::irq_set_t irq_clr;

	// Bus port latch, reset to all ones so open-drain pins float
	always_ff @(posedge ref_clk_i) begin
		if (srst_i)
			bus_latch <= port_pins_pkg::BUS_PORT_RESET_LATCH;
		else if (bus_latch_we_i)
			bus_latch <= bus_latch_wdata_i;
	end

	// Bus phase follows the strobe
	always_ff @(posedge ref_clk_i) begin
		if (srst_i)
			phase <= port_pins_pkg::BUS_IDLE;
		else if (!ext_bus_en_i)
			phase <= port_pins_pkg::BUS_IDLE;
		else if (addr_strobe_i)
			phase <= port_pins_pkg::BUS_ADDR;
		else
			phase <= port_pins_pkg::BUS_DATA;
	end

	// Registered bus port drive
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			bus_drv <= '0;
		end else begin
			case (phase)
			port_pins_pkg::BUS_ADDR: begin
				bus_drv.o <= low_addr_i;
				bus_drv.oe <= ~low_addr_i;
				bus_drv.wpu <= low_addr_i;
			end
			port_pins_pkg::BUS_DATA: begin
				bus_drv.o <= data_out_i;
				bus_drv.oe <= data_drive_i ? ~data_out_i : 8'h00;
				bus_drv.wpu <= data_drive_i ? data_out_i : 8'h00;
			end
			default: begin
				// Open drain as plain I/O: only pulls low, external pullups needed
				bus_drv.o <= 8'h00;
				bus_drv.oe <= ~bus_latch;
				bus_drv.wpu <= 8'h00;
			end
			endcase
		end
	end

	assign muxed_addr_data_bus_o = bus_drv.o;
	assign muxed_addr_data_bus_oe_o = bus_drv.oe;
	assign muxed_addr_data_bus_wpu_o = bus_drv.wpu;

	always_ff @(posedge ref_clk_i) begin
		if (srst_i)
			bus_pin_level_o <= 8'hFF;
		else
			bus_pin_level_o <= muxed_addr_data_bus_i;
	end

	// I/O port latch
	always_ff @(posedge ref_clk_i) begin
		if (srst_i)
			io_latch <= port_pins_pkg::IO_PORT_RESET_LATCH;
		else if (io_latch_we_i)
			io_latch <= io_latch_wdata_i;
	end

	assign io_latch_o = io_latch;

	// Output seen by each pin: latch ANDed with the alternate output where alt_enable_i is set, so a latch of one hands the pin over
	assign eff_io = io_latch & (~alt_enable_i | alt_out_i);

	// Per-pin strong pullup timer, started when a pin goes from low to high
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			for (int i = 0; i < WIDTH; i++)
				pulse_cnt[i] <= 8'h00;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (!eff_io[i])
					pulse_cnt[i] <= 8'h00;
				else if (!io_drv.o[i])
					pulse_cnt[i] <= 8'(PULSE_CYCLES);
				else if (pulse_cnt[i] != 8'h00)
					pulse_cnt[i] <= pulse_cnt[i] - 8'h01;
			end
		end
	end

	// Each pin ends its strong drive on its own last count, so the pullup lasts PULSE_CYCLES
	always_comb begin
		pulse_active = 8'h00;
		pulse_last = 8'h00;
		for (int i = 0; i < WIDTH; i++) begin
			pulse_active[i] = (pulse_cnt[i] != 8'h00);
			pulse_last[i] = (pulse_cnt[i] == 8'h01);
		end
	end

	// Registered I/O drive: low strong, high weak, brief strong after a rise
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			io_drv.o <= 8'hFF;
			io_drv.oe <= 8'h00;
			io_drv.wpu <= 8'hFF;
		end else begin
			io_drv.o <= eff_io;
			io_drv.oe <= ~eff_io | (eff_io & ~io_drv.o) | (eff_io & pulse_active & ~pulse_last);
			io_drv.wpu <= eff_io;
		end
	end

	assign io_pin_o = io_drv.o;
	assign io_pin_oe_o = io_drv.oe;
	assign io_pin_wpu_o = io_drv.wpu;

	// Pins read back what is really on the wire
	always_ff @(posedge ref_clk_i) begin
		if (srst_i)
			io_pin_level_o <= 8'hFF;
		else
			io_pin_level_o <= io_pin_i;
	end

	// Alternate inputs tapped from sampled pin levels
	assign timer_two_io_o = io_pin_level_o[port_pins_pkg::TIMER_IO_BIT];
	assign timer_two_reload_trigger_o = io_pin_level_o[port_pins_pkg::TIMER_TRIG_BIT];
	assign second_serial_receive_o = io_pin_level_o[port_pins_pkg::SERIAL_RX_BIT];

	assign irq_clr = {4{irq_clear_i}};

	edge_irq_flag #(.RISING(1'b1)) u_irq_two (
		.ref_clk_i(ref_clk_i),
		.srst_i(srst_i),
		.pin_i(io_pin_i[port_pins_pkg::IRQ_TWO_BIT]),
		.clear_i(irq_clr.edge_irq_two),
		.pending_o(irq_pending_o.edge_irq_two)
	);
	edge_irq_flag #(.RISING(1'b0)) u_irq_three (
		.ref_clk_i(ref_clk_i),
		.srst_i(srst_i),
		.pin_i(io_pin_i[port_pins_pkg::IRQ_THREE_BIT]),
		.clear_i(irq_clr.edge_irq_three),
		.pending_o(irq_pending_o.edge_irq_three)
	);
	edge_irq_flag #(.RISING(1'b1)) u_irq_four (
		.ref_clk_i(ref_clk_i),
		.srst_i(srst_i),
		.pin_i(io_pin_i[port_pins_pkg::IRQ_FOUR_BIT]),
		.clear_i(irq_clr.edge_irq_four),
		.pending_o(irq_pending_o.edge_irq_four)
	);
	edge_irq_flag #(.RISING(1'b0)) u_irq_five (
		.ref_clk_i(ref_clk_i),
		.srst_i(srst_i),
		.pin_i(io_pin_i[port_pins_pkg::IRQ_FIVE_BIT]),
		.clear_i(irq_clr.edge_irq_five),
		.pending_o(irq_pending_o.edge_irq_five)
	);
endmodule : port_pins
`default_nettype wire

// ==== port_pins_chk.sv ====
// Assertions on the ports of port_pins.
// Assumes one clock domain and pins held steady across reset.
`default_nettype none
module port_pins_chk (
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic ext_bus_en_i,
	input wire logic addr_strobe_i,
	input wire logic [7:0] low_addr_i,
	input wire logic [7:0] muxed_addr_data_bus_oe_o,
	input wire logic [7:0] muxed_addr_data_bus_wpu_o,
	input wire logic io_latch_we_i,
	input wire logic [7:0] io_latch_wdata_i,
	input wire logic [7:0] alt_enable_i,
	input wire logic [7:0] io_latch_o,
	input wire logic [7:0] io_pin_o,
	input wire logic [7:0] io_pin_oe_o,
	input wire logic [7:0] io_pin_wpu_o,
	input wire logic [7:0] io_pin_i,
	input wire logic irq_clear_i,
	input wire port_pins_pkg::irq_set_t irq_pending_o
);
	default clocking @(posedge ref_clk_i);
	endclocking
	default disable iff (srst_i);
	sequence s_write_zero;
		io_latch_we_i && io_latch_wdata_i == 8'h00 && alt_enable_i == 8'h00;
	endsequence
	sequence s_write_one;
		io_latch_we_i && io_latch_o == 8'h00 && io_latch_wdata_i == 8'hFF && alt_enable_i == 8'h00;
	endsequence
	property p_bus_rst;
		$fell(srst_i) |-> (muxed_addr_data_bus_oe_o | muxed_addr_data_bus_wpu_o) == 8'h00;
	endproperty
	a_bus_rst: assert property (p_bus_rst) else $error("bus port not floating after reset");
	property p_io_rst;
		$fell(srst_i) |-> io_latch_o == 8'hFF && io_pin_wpu_o == 8'hFF && io_pin_oe_o == 8'h00;
	endproperty
	a_io_rst: assert property (p_io_rst) else $error("io port not weakly high after reset");
	property p_pulldown;
		s_write_zero |-> ##2 io_pin_oe_o == 8'hFF && io_pin_o == 8'h00;
	endproperty
	a_pulldown: assert property (p_pulldown) else $error("no strong pulldown after zero write");
	property p_pullup;
		s_write_one |-> ##2 (io_pin_oe_o & io_pin_o) == 8'hFF ##[1:4] io_pin_oe_o == 8'h00 && io_pin_wpu_o == 8'hFF;
	endproperty
	a_pullup: assert property (p_pullup) else $error("strong pullup pulse wrong");
	property p_addr;
		(ext_bus_en_i && addr_strobe_i && $stable(low_addr_i))[*3] |->
			muxed_addr_data_bus_oe_o == ~low_addr_i && muxed_addr_data_bus_wpu_o == low_addr_i;
	endproperty
	a_addr: assert property (p_addr) else $error("address phase drive wrong");
	property p_irq_rise;
		$rose(io_pin_i[4]) |-> ##[2:5] irq_pending_o.edge_irq_two;
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("rising edge not flagged");
	property p_irq_fall;
		$fell(io_pin_i[5]) |-> ##[2:5] irq_pending_o.edge_irq_three;
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("falling edge not flagged");
	property p_irq_hold;
		irq_pending_o.edge_irq_four && !irq_clear_i |=> irq_pending_o.edge_irq_four;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("pending flag lost");
endmodule : port_pins_chk
bind port_pins port_pins_chk u_port_pins_chk (.*);
`default_nettype wire

// ==== pin_world.sv ====
// Board model: resolves pins from the block drive and outside pull-downs.
// Assumes outside circuits only pull low; an undriven pin shows the inverse of its last level.
`default_nettype none
module pin_world (
	input wire logic ref_clk_i,
	input wire logic [7:0] o_i,
	input wire logic [7:0] oe_i,
	input wire logic [7:0] wpu_i,
	input wire logic [7:0] pull_low_i,
	output logic [7:0] pin_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] last = 8'h00;
	always_ff @(posedge ref_clk_i) last <= pin_o;
	// A pull-low overcomes the weak pullup but not a strong drive
	assign pin_o = (oe_i & o_i) | (~oe_i & ~pull_low_i & (wpu_i | ~last));
endmodule : pin_world
`default_nettype wire

// ==== port_pins_test.sv ====
// Self-checking bench for port_pins with a board model on each port.
// Assumes the block answers within a few cycles of each change.
`default_nettype none
module port_pins_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk_i = 1'b0, srst_i = 1'b1, bus_latch_we_i = 1'b0, ext_bus_en_i = 1'b0, addr_strobe_i = 1'b0;
	logic data_drive_i = 1'b0, io_latch_we_i = 1'b0, irq_clear_i = 1'b0;
	logic [7:0] bus_latch_wdata_i = 8'h00, low_addr_i = 8'h00, data_out_i = 8'h00, io_latch_wdata_i = 8'h00;
	logic [7:0] alt_enable_i = 8'h00, alt_out_i = 8'hFF, pull = 8'h00;
	logic [7:0] muxed_addr_data_bus_o, muxed_addr_data_bus_oe_o, muxed_addr_data_bus_wpu_o, muxed_addr_data_bus_i;
	logic [7:0] bus_pin_level_o, io_pin_o, io_pin_oe_o, io_pin_wpu_o, io_pin_i, io_latch_o, io_pin_level_o;
	logic timer_two_io_o, timer_two_reload_trigger_o, second_serial_receive_o;
	port_pins_pkg::irq_set_t irq_pending_o;
	int mismatches = 0;
	int compares = 0;
	port_pins u_port_pins (.*);
	pin_world u_pin_world (.ref_clk_i, .o_i(muxed_addr_data_bus_o), .oe_i(muxed_addr_data_bus_oe_o),
		.wpu_i(muxed_addr_data_bus_wpu_o), .pull_low_i(8'h00), .pin_o(muxed_addr_data_bus_i));
	pin_world u_pin_world_io (.ref_clk_i, .o_i(io_pin_o), .oe_i(io_pin_oe_o), .wpu_i(io_pin_wpu_o),
		.pull_low_i(pull), .pin_o(io_pin_i));
	initial forever #10 ref_clk_i = ~ref_clk_i;
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask : cyc
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] d);
		io_latch_wdata_i = d;
		io_latch_we_i = 1'b1;
		cyc(1);
		io_latch_we_i = 1'b0;
	endtask : wr
	task automatic conclude;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : conclude
	task automatic test_quasi;
		wr(8'h00);
		cyc(3);
		chk(io_pin_oe_o & ~io_pin_o, 8'hFF);
		chk(io_pin_level_o, 8'h00);
		wr(8'hFF);
		cyc(2);
		chk(io_pin_oe_o & io_pin_o, 8'hFF);
		cyc(4);
		chk(io_pin_oe_o, 8'h00);
		chk(io_pin_wpu_o, 8'hFF);
		pull = 8'h0F;
		cyc(4);
		chk(io_pin_level_o, 8'hF0);
		chk({5'h1F, second_serial_receive_o, timer_two_reload_trigger_o, timer_two_io_o}, 8'hF8);
		pull = 8'h00;
		alt_enable_i = 8'h08;
		alt_out_i = 8'h00;
		cyc(5);
		chk(io_pin_level_o, 8'hF7);
		alt_enable_i = 8'h00;
		$display("test_quasi done");
	endtask : test_quasi
	task automatic test_irq;
		// Earlier writes toggled the interrupt pins, so start from cleared flags
		irq_clear_i = 1'b1;
		cyc(1);
		irq_clear_i = 1'b0;
		pull = 8'h50;
		cyc(8);
		chk({4'h0, irq_pending_o}, 8'h00);
		pull = 8'h00;
		cyc(8);
		chk({4'h0, irq_pending_o}, 8'h05);
		pull = 8'hA0;
		cyc(8);
		chk({4'h0, irq_pending_o}, 8'h0F);
		irq_clear_i = 1'b1;
		cyc(1);
		irq_clear_i = 1'b0;
		pull = 8'h00;
		cyc(8);
		chk({4'h0, irq_pending_o}, 8'h00);
		$display("test_irq done");
	endtask : test_irq
	task automatic test_bus;
		ext_bus_en_i = 1'b1;
		addr_strobe_i = 1'b1;
		low_addr_i = 8'h5A;
		cyc(4);
		chk(muxed_addr_data_bus_oe_o, 8'hA5);
		chk(muxed_addr_data_bus_wpu_o, 8'h5A);
		chk(muxed_addr_data_bus_o, 8'h5A);
		chk(bus_pin_level_o, 8'h5A);
		addr_strobe_i = 1'b0;
		data_drive_i = 1'b1;
		data_out_i = 8'h3C;
		cyc(4);
		chk(muxed_addr_data_bus_oe_o, 8'hC3);
		chk(bus_pin_level_o, 8'h3C);
		ext_bus_en_i = 1'b0;
		data_drive_i = 1'b0;
		bus_latch_wdata_i = 8'h0F;
		bus_latch_we_i = 1'b1;
		cyc(1);
		bus_latch_we_i = 1'b0;
		cyc(3);
		chk(muxed_addr_data_bus_oe_o | muxed_addr_data_bus_wpu_o, 8'hF0);
		$display("test_bus done");
	endtask : test_bus
	initial begin
		cyc(6);
		srst_i = 1'b0;
		cyc(1);
		chk(muxed_addr_data_bus_oe_o | muxed_addr_data_bus_wpu_o, 8'h00);
		chk(io_latch_o & io_pin_wpu_o & ~io_pin_oe_o, 8'hFF);
		test_quasi();
		test_irq();
		test_bus();
		conclude();
	end
	// Cuts a hang short
	initial begin
		#100us;
		mismatches++;
		conclude();
	end
endmodule : port_pins_test
`default_nettype wire
